// >>> tcpif_cfg.svh
// Purpose: Offsets, bit positions and reset values of the port interrupt flags
// Assumes: Byte-wide register port, one clock
// Notes:   Definitions only
`ifndef TCPIF_CFG_SVH
`define TCPIF_CFG_SVH

`define TCPIF_DATA_W                  8
`define TCPIF_LVL_W                   2
`define TCPIF_ADDR_PRIMARY            8'h14
`define TCPIF_ADDR_SECONDARY          8'h15
`define TCPIF_FLAGS_RESET             8'h00
`define TCPIF_LVL_RESET               2'h0
`define TCPIF_PRI_VALID               8'h07
`define TCPIF_SEC_VALID               8'h6F

`define TCPIF_ATTACH_EVENT_FLAG       0
`define TCPIF_DETACH_EVENT_FLAG       1
`define TCPIF_CURRENT_LEVEL_CHANGE    2

`define TCPIF_REMEDY_STARTED_FLAG     0
`define TCPIF_FORCED_ROLE_DONE_FLAG   1
`define TCPIF_FORCED_ROLE_FAILED_FLAG 2
`define TCPIF_REMEDY_FAILED_FLAG      3
`define TCPIF_RESERVED_LOW            4
`define TCPIF_REMEDY_VBUS_ON_REQUEST  5
`define TCPIF_REMEDY_VBUS_OFF_REQUEST 6
`define TCPIF_RESERVED_HIGH           7

`endif

// >>> tcpif_pkg.sv
// Purpose: Shared types of the port interrupt flags
// Assumes: Constants live in tcpif_cfg.svh
// Notes:   Types only
`default_nettype none
`include "tcpif_cfg.svh"

package tcpif_pkg;
  typedef logic [`TCPIF_DATA_W-1:0] tcpif_byte_t;
  typedef logic [`TCPIF_LVL_W-1:0]  tcpif_lvl_t;
endpackage

`default_nettype wire

// >>> tcpif_bank_if.sv
// Purpose: Set, clear and flag lines between top and a flag bank
// Assumes: One clock domain
// Notes:   Owner holds the flags
`timescale 1ns/1ps
`default_nettype none

interface tcpif_bank_if;
  tcpif_pkg::tcpif_byte_t set;
  tcpif_pkg::tcpif_byte_t clr;
  tcpif_pkg::tcpif_byte_t flags;
  modport owner (input set, input clr, output flags);
  modport user  (output set, output clr, input flags);
endinterface

`default_nettype wire

// >>> tcpif_w1c_bank.sv
// Purpose: Eight sticky flags, set by events, cleared by writing one
// Assumes: Set and clear are one-cycle strobes on sys_clk_i
// Notes:   Bits outside VALID stay zero
`timescale 1ns/1ps
`default_nettype none
`include "tcpif_cfg.svh"

module tcpif_w1c_bank #(
  parameter tcpif_pkg::tcpif_byte_t VALID = `TCPIF_SEC_VALID
) (
  input  wire logic         sys_clk_i,
  input  wire logic         rst_i,
  tcpif_bank_if.owner       bank
);

  tcpif_pkg::tcpif_byte_t flag_r;
  tcpif_pkg::tcpif_byte_t flag_nxt;

  // Set beats a clear in the same cycle
  always_comb begin
    flag_nxt = ((flag_r & ~bank.clr) | bank.set) & VALID; // see RULE_04 see RULE_12 see RULE_14
  end

  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      flag_r <= `TCPIF_FLAGS_RESET;
    end else begin
      flag_r <= flag_nxt;
    end
  end

  assign bank.flags = flag_r;

  genvar gi;
  generate
    for (gi = 0; gi < `TCPIF_DATA_W; gi++) begin : g_chk
      if (VALID[gi]) begin : g_valid
        a_set_wins_clear: assert property (@(posedge sys_clk_i) disable iff (rst_i) // see RULE_04
          bank.set[gi] |=> flag_r[gi])
          else $error("flag lost on set");
        a_clear_takes: assert property (@(posedge sys_clk_i) disable iff (rst_i) // see RULE_04
          (bank.clr[gi] && !bank.set[gi]) |=> !flag_r[gi])
          else $error("flag not cleared");
        a_flag_holds: assert property (@(posedge sys_clk_i) disable iff (rst_i) // see RULE_04
          (flag_r[gi] && !bank.clr[gi]) |=> flag_r[gi])
          else $error("flag dropped by itself");
      end else begin : g_rsvd
        a_reserved_zero: assert property (@(posedge sys_clk_i) disable iff (rst_i) // see RULE_14
          !flag_r[gi])
          else $error("reserved bit set");
      end
    end
  endgenerate

endmodule // tcpif_w1c_bank

`default_nettype wire

// >>> tcpif_flags.sv
// Purpose: Primary and secondary interrupt flag registers and interrupt pin
// Assumes: Event inputs come from logic on sys_clk_i; masks from the mask registers
// Notes:   Register port is the byte port behind the serial interface
// Behaviour
// RULE_01 - Level change sets primary bit two
// RULE_02 - Detach sets primary bit one
// RULE_03 - Attach sets primary bit zero
// RULE_04 - Secondary at 15h, zero reset, write-one-clears
// RULE_05 - Remedy VBUS-off request sets secondary bit six
// RULE_06 - Remedy VBUS-on request sets secondary bit five
// RULE_07 - Remedy failure sets secondary bit three
// RULE_08 - Forced role failure sets secondary bit two
// RULE_09 - Forced role success sets secondary bit one
// RULE_10 - Remedy start sets secondary bit zero
// RULE_11 - Mask blocks pin, flag still sets
// RULE_12 - Primary at 14h, zero reset, write-one-clears
// RULE_13 - Pin low while any unmasked flag set
// RULE_14 - Secondary bits seven, four read zero
`timescale 1ns/1ps
`default_nettype none
`include "tcpif_cfg.svh"

module tcpif_flags (
  input  wire logic                     sys_clk_i,
  input  wire logic                     rst_i,
  input  wire tcpif_pkg::tcpif_lvl_t    advertised_current_level_i,
  input  wire logic                     attach_active_i,
  input  wire logic                     remedy_vbus_off_request_i,
  input  wire logic                     remedy_vbus_on_request_i,
  input  wire logic                     remedy_failed_i,
  input  wire logic                     forced_role_failed_i,
  input  wire logic                     forced_role_done_i,
  input  wire logic                     remedy_started_i,
  input  wire tcpif_pkg::tcpif_byte_t   primary_mask_i,
  input  wire tcpif_pkg::tcpif_byte_t   secondary_mask_i,
  input  wire tcpif_pkg::tcpif_byte_t   reg_addr_i,
  input  wire logic                     reg_wr_i,
  input  wire tcpif_pkg::tcpif_byte_t   reg_wdata_i,
  input  wire logic                     reg_rd_i,
  output logic [`TCPIF_DATA_W-1:0]      reg_rdata_o,
  output logic                          int_n_o
);

  tcpif_bank_if pri_if ();
  tcpif_bank_if sec_if ();

  tcpif_pkg::tcpif_lvl_t  lvl_prev_r;
  logic                   attach_prev_r;
  logic                   lvl_change;
  logic                   attach_rise;
  logic                   attach_fall;
  logic                   pri_wr;
  logic                   sec_wr;
  tcpif_pkg::tcpif_byte_t pending;
  tcpif_pkg::tcpif_byte_t rdata_r;
  logic                   int_n_r;

  // Previous values for edge and change detection
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      lvl_prev_r    <= `TCPIF_LVL_RESET;
      attach_prev_r <= 1'b0;
    end else begin
      lvl_prev_r    <= advertised_current_level_i;
      attach_prev_r <= attach_active_i;
    end
  end

  assign lvl_change  = (advertised_current_level_i != lvl_prev_r); // see RULE_01
  assign attach_rise = attach_active_i && !attach_prev_r;          // see RULE_03
  assign attach_fall = !attach_active_i && attach_prev_r;          // see RULE_02

  // Register write decode
  assign pri_wr = reg_wr_i && (reg_addr_i == `TCPIF_ADDR_PRIMARY);   // see RULE_12
  assign sec_wr = reg_wr_i && (reg_addr_i == `TCPIF_ADDR_SECONDARY); // see RULE_04

  // Primary event set vector
  always_comb begin
    pri_if.set = `TCPIF_FLAGS_RESET;
    pri_if.set[`TCPIF_CURRENT_LEVEL_CHANGE] = lvl_change;  // see RULE_01
    pri_if.set[`TCPIF_DETACH_EVENT_FLAG]    = attach_fall; // see RULE_02
    pri_if.set[`TCPIF_ATTACH_EVENT_FLAG]    = attach_rise; // see RULE_03
    pri_if.clr = pri_wr ? reg_wdata_i : `TCPIF_FLAGS_RESET; // see RULE_12
  end

  // Secondary event set vector
  always_comb begin
    sec_if.set = `TCPIF_FLAGS_RESET;
    sec_if.set[`TCPIF_REMEDY_VBUS_OFF_REQUEST] = remedy_vbus_off_request_i; // see RULE_05
    sec_if.set[`TCPIF_REMEDY_VBUS_ON_REQUEST]  = remedy_vbus_on_request_i;  // see RULE_06
    sec_if.set[`TCPIF_REMEDY_FAILED_FLAG]      = remedy_failed_i;           // see RULE_07
    sec_if.set[`TCPIF_FORCED_ROLE_FAILED_FLAG] = forced_role_failed_i;      // see RULE_08
    sec_if.set[`TCPIF_FORCED_ROLE_DONE_FLAG]   = forced_role_done_i;        // see RULE_09
    sec_if.set[`TCPIF_REMEDY_STARTED_FLAG]     = remedy_started_i;          // see RULE_10
    sec_if.clr = sec_wr ? reg_wdata_i : `TCPIF_FLAGS_RESET; // see RULE_04
  end

  tcpif_w1c_bank #(
    .VALID (`TCPIF_PRI_VALID)
  ) u_pri_bank (
    .sys_clk_i (sys_clk_i),
    .rst_i     (rst_i),
    .bank      (pri_if.owner)
  );

  tcpif_w1c_bank #(
    .VALID (`TCPIF_SEC_VALID)
  ) u_sec_bank (
    .sys_clk_i (sys_clk_i),
    .rst_i     (rst_i),
    .bank      (sec_if.owner)
  );

  // Unmasked pending flags; masked flags still set
  assign pending = (pri_if.flags & ~primary_mask_i) | (sec_if.flags & ~secondary_mask_i); // see RULE_11

  // Interrupt pin, active low
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      int_n_r <= 1'b1;
    end else begin
      int_n_r <= ~(|pending); // see RULE_13
    end
  end

  // Read data, captured on read strobe; unmapped reads give zero
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      rdata_r <= `TCPIF_FLAGS_RESET;
    end else if (reg_rd_i) begin
      case (reg_addr_i)
        `TCPIF_ADDR_PRIMARY:   rdata_r <= pri_if.flags;  // see RULE_12
        `TCPIF_ADDR_SECONDARY: rdata_r <= sec_if.flags;  // see RULE_04
        default:               rdata_r <= `TCPIF_FLAGS_RESET;
      endcase
    end
  end

  assign reg_rdata_o = rdata_r;
  assign int_n_o     = int_n_r;

  // Checks
  sequence s_sec_clear_write(int b);
    sec_wr && reg_wdata_i[b] && !sec_if.set[b];
  endsequence

  sequence s_sec_read;
    reg_rd_i && (reg_addr_i == `TCPIF_ADDR_SECONDARY);
  endsequence

  a_lvl_change_flag: assert property (@(posedge sys_clk_i) disable iff (rst_i) // see RULE_01
    $changed(advertised_current_level_i) && !pri_wr
      |=> pri_if.flags[`TCPIF_CURRENT_LEVEL_CHANGE])
    else $error("level change not flagged");

  a_detach_flag: assert property (@(posedge sys_clk_i) disable iff (rst_i) // see RULE_02
    $fell(attach_active_i) |=> pri_if.flags[`TCPIF_DETACH_EVENT_FLAG])
    else $error("detach not flagged");

  a_attach_flag: assert property (@(posedge sys_clk_i) disable iff (rst_i) // see RULE_03
    $rose(attach_active_i) |=> pri_if.flags[`TCPIF_ATTACH_EVENT_FLAG])
    else $error("attach not flagged");

  a_sec_w1c_read: assert property (@(posedge sys_clk_i) disable iff (rst_i) // see RULE_04
    s_sec_clear_write(`TCPIF_FORCED_ROLE_DONE_FLAG) ##1 s_sec_read
      |=> !reg_rdata_o[`TCPIF_FORCED_ROLE_DONE_FLAG])
    else $error("cleared flag read back set");

  a_vbus_off_req: assert property (@(posedge sys_clk_i) disable iff (rst_i) // see RULE_05
    remedy_vbus_off_request_i |=> sec_if.flags[`TCPIF_REMEDY_VBUS_OFF_REQUEST])
    else $error("vbus off request lost");

  a_vbus_on_req: assert property (@(posedge sys_clk_i) disable iff (rst_i) // see RULE_06
    remedy_vbus_on_request_i |=> sec_if.flags[`TCPIF_REMEDY_VBUS_ON_REQUEST])
    else $error("vbus on request lost");

  a_remedy_fail: assert property (@(posedge sys_clk_i) disable iff (rst_i) // see RULE_07
    remedy_failed_i ##1 s_sec_read |=> reg_rdata_o[`TCPIF_REMEDY_FAILED_FLAG])
    else $error("remedy failure not readable");

  a_force_fail: assert property (@(posedge sys_clk_i) disable iff (rst_i) // see RULE_08
    forced_role_failed_i |=> sec_if.flags[`TCPIF_FORCED_ROLE_FAILED_FLAG])
    else $error("forced role failure lost");

  a_force_done: assert property (@(posedge sys_clk_i) disable iff (rst_i) // see RULE_09
    forced_role_done_i |=> sec_if.flags[`TCPIF_FORCED_ROLE_DONE_FLAG])
    else $error("forced role success lost");

  a_remedy_start: assert property (@(posedge sys_clk_i) disable iff (rst_i) // see RULE_10
    remedy_started_i |=> sec_if.flags[`TCPIF_REMEDY_STARTED_FLAG])
    else $error("remedy start lost");

  a_mask_blocks_pin: assert property (@(posedge sys_clk_i) disable iff (rst_i) // see RULE_11
    ((pri_if.flags & ~primary_mask_i) == `TCPIF_FLAGS_RESET)
      && ((sec_if.flags & ~secondary_mask_i) == `TCPIF_FLAGS_RESET) |=> int_n_o)
    else $error("masked flag drove pin");

  a_pri_w1c: assert property (@(posedge sys_clk_i) disable iff (rst_i) // see RULE_12
    pri_wr && reg_wdata_i[`TCPIF_ATTACH_EVENT_FLAG] && !attach_rise
      |=> !pri_if.flags[`TCPIF_ATTACH_EVENT_FLAG])
    else $error("primary flag not cleared");

  a_pin_asserts: assert property (@(posedge sys_clk_i) disable iff (rst_i) // see RULE_13
    (|pending) |=> !int_n_o)
    else $error("pin not asserted");

  a_rsvd_read_zero: assert property (@(posedge sys_clk_i) disable iff (rst_i) // see RULE_14
    s_sec_read |=> !reg_rdata_o[`TCPIF_RESERVED_HIGH] && !reg_rdata_o[`TCPIF_RESERVED_LOW])
    else $error("reserved bit read nonzero");

endmodule // tcpif_flags

`default_nettype wire

// >>> tcpif_host_model.sv
// Purpose: Host side of the flag registers over the byte strobe port
// Assumes: Calls start 2 ns after a rising clock edge
// Notes:   Address and data are scrambled while idle
`timescale 1ns/1ps
`default_nettype none

module tcpif_host_model (
  input  wire logic                    sys_clk_i,
  input  wire tcpif_pkg::tcpif_byte_t  reg_rdata_i,
  output var tcpif_pkg::tcpif_byte_t   reg_addr_o,
  output var logic                     reg_wr_o,
  output var tcpif_pkg::tcpif_byte_t   reg_wdata_o,
  output var logic                     reg_rd_o
);
  initial begin
    reg_addr_o = 8'hA5;
    reg_wdata_o = 8'h5A;
    reg_wr_o = 1'b0;
    reg_rd_o = 1'b0;
  end

  // Clears flags by writing ones; one idle edge closes the call
  task automatic wr(input tcpif_pkg::tcpif_byte_t a, input tcpif_pkg::tcpif_byte_t d);
    reg_addr_o = a;
    reg_wdata_o = d;
    reg_wr_o = 1'b1;
    @(posedge sys_clk_i);
    #2;
    reg_wr_o = 1'b0;
    reg_addr_o = ~a;
    reg_wdata_o = ~d;
    @(posedge sys_clk_i);
    #2;
  endtask

  // Read strobe, data taken one edge later
  task automatic rd(input tcpif_pkg::tcpif_byte_t a, output tcpif_pkg::tcpif_byte_t d);
    reg_addr_o = a;
    reg_rd_o = 1'b1;
    @(posedge sys_clk_i);
    #2;
    reg_rd_o = 1'b0;
    reg_addr_o = ~a;
    @(posedge sys_clk_i);
    #1;
    d = reg_rdata_i;
    #1;
  endtask
endmodule // tcpif_host_model

`default_nettype wire

// >>> tcpif_flags_tb.sv
// Purpose: Self-checking bench of the port interrupt flags
// Assumes: 40 MHz clock, inputs change 2 ns after rising edge
// Notes:   Host model drives the register port
`timescale 1ns/1ps
`default_nettype none
`include "tcpif_cfg.svh"

module tcpif_flags_tb;
  localparam tcpif_pkg::tcpif_byte_t PRI = `TCPIF_ADDR_PRIMARY;
  localparam tcpif_pkg::tcpif_byte_t SEC = `TCPIF_ADDR_SECONDARY;
  logic                   sys_clk;
  logic                   rst;
  logic                   attach;
  logic                   wr;
  logic                   rd;
  logic                   int_n;
  tcpif_pkg::tcpif_lvl_t  lvl;
  tcpif_pkg::tcpif_byte_t sec_ev, pmask, smask, addr, wdata, rdata, got;
  int                     error_cnt = 0;
  int                     n_checks = 0;
  int                     bits[6] = '{0, 1, 2, 3, 5, 6};

  tcpif_flags uut (
    .sys_clk_i(sys_clk), .rst_i(rst), .advertised_current_level_i(lvl),
    .attach_active_i(attach), .remedy_vbus_off_request_i(sec_ev[6]),
    .remedy_vbus_on_request_i(sec_ev[5]), .remedy_failed_i(sec_ev[3]),
    .forced_role_failed_i(sec_ev[2]), .forced_role_done_i(sec_ev[1]),
    .remedy_started_i(sec_ev[0]), .primary_mask_i(pmask), .secondary_mask_i(smask),
    .reg_addr_i(addr), .reg_wr_i(wr), .reg_wdata_i(wdata), .reg_rd_i(rd),
    .reg_rdata_o(rdata), .int_n_o(int_n)
  );

  tcpif_host_model host (
    .sys_clk_i(sys_clk), .reg_rdata_i(rdata), .reg_addr_o(addr),
    .reg_wr_o(wr), .reg_wdata_o(wdata), .reg_rd_o(rd)
  );

  initial begin
    sys_clk = 1'b0;
    forever #12.5 sys_clk = ~sys_clk;
  end

  task automatic tally_and_finish;
    $display("Checks %0d, errors %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  task automatic chk(input tcpif_pkg::tcpif_byte_t g, input tcpif_pkg::tcpif_byte_t e);
    n_checks++;
    if (g !== e) begin
      error_cnt++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk);
    #2;
  endtask

  task automatic rdchk(input tcpif_pkg::tcpif_byte_t a, input tcpif_pkg::tcpif_byte_t e);
    host.rd(a, got);
    chk(got, e);
  endtask

  task automatic pin(input logic e);
    chk({7'h00, int_n}, {7'h00, e});
  endtask

  initial begin
    #500000;
    error_cnt++;
    tally_and_finish();
  end

  initial begin
    lvl = 2'h0;
    attach = 1'b0;
    sec_ev = 8'h00;
    pmask = 8'h00;
    smask = 8'h00;
    rst = 1'b1;
    repeat (16) @(posedge sys_clk);
    #2 rst = 1'b0;
    tick(1);
    pin(1'b1);
    rdchk(PRI, 8'h00);
    rdchk(SEC, 8'h00);
    // Each secondary event sets its bit and drives the pin
    foreach (bits[i]) begin
      sec_ev[bits[i]] = 1'b1;
      tick(1);
      sec_ev = 8'h00;
      tick(1);
      pin(1'b0);
      rdchk(SEC, 8'h01 << bits[i]);
      host.wr(SEC, 8'h01 << bits[i]);
      tick(1);
      pin(1'b1);
      rdchk(SEC, 8'h00);
    end
    // Masked flag sets but leaves the pin alone
    smask = 8'h08;
    sec_ev = 8'h6F;
    tick(1);
    sec_ev = 8'h00;
    smask = 8'h6F;
    tick(1);
    pin(1'b1);
    rdchk(SEC, 8'h6F);
    host.wr(SEC, 8'h90);
    rdchk(SEC, 8'h6F);
    host.wr(8'h13, 8'hFF);
    rdchk(8'h16, 8'h00);
    rdchk(SEC, 8'h6F);
    smask = 8'h00;
    tick(1);
    pin(1'b0);
    // Event in the clearing cycle keeps its flag
    sec_ev[0] = 1'b1;
    fork
      host.wr(SEC, 8'hFF);
      begin
        tick(1);
        sec_ev = 8'h00;
      end
    join
    rdchk(SEC, 8'h01);
    host.wr(SEC, 8'h01);
    // Primary flags under mask
    pmask = 8'h07;
    attach = 1'b1;
    tick(1);
    rdchk(PRI, 8'h01);
    pin(1'b1);
    attach = 1'b0;
    tick(1);
    rdchk(PRI, 8'h03);
    lvl = 2'h2;
    tick(1);
    rdchk(PRI, 8'h07);
    pmask = 8'h03;
    tick(1);
    pin(1'b0);
    host.wr(PRI, 8'h04);
    tick(1);
    pin(1'b1);
    rdchk(PRI, 8'h03);
    host.wr(PRI, 8'h03);
    rdchk(PRI, 8'h00);
    // Mid-run reset clears flags; held level flags a change after release
    sec_ev = 8'h01;
    tick(1);
    sec_ev = 8'h00;
    rst = 1'b1;
    tick(1);
    rst = 1'b0;
    tick(1);
    pin(1'b1);
    rdchk(SEC, 8'h00);
    rdchk(PRI, 8'h04);
    tally_and_finish();
  end
endmodule // tcpif_flags_tb

`default_nettype wire
